// ===== hdl/adcsp_edge.sv
/*
  Edge finder for a vector of synchronised levels.
  Assumes inputs are already in the clk domain.
*/
`timescale 1ns/1ns
module adcsp_edge #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] prev;
  } adcsp_edge_t;

  adcsp_edge_t s_r;
  adcsp_edge_t s_nxt;

  always_comb begin
    s_nxt.prev = lvl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= RST_VAL;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rise = lvl & ~s_r.prev;
  assign fall = s_r.prev & ~lvl;
endmodule : adcsp_edge

// ===== hdl/adcsp_pkg.sv
/*
  Constants and types for the converter serial host port.
  Assumes a single clk domain; pin inputs are synchronised before use.
*/
package adcsp_pkg;
  // ==========================================================
  // Widths
  localparam int CMD_W = 4;
  localparam int RES_W = 10;
  localparam int CNT_W = 5;
  localparam int PIN_W = 3;
  // ==========================================================
  // Pin slots in the synchroniser vector
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_FS = 2;
  localparam logic [PIN_W-1:0] PIN_RST = 3'h5;
  // ==========================================================
  // Edge counts within a transfer
  localparam logic [2:0] CMD_EDGES = 3'h4;
  localparam logic [CNT_W-1:0] SAMPLE_EDGE = 5'h04;
  localparam logic [CNT_W-1:0] CONV_EDGE = 5'h0A;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
  localparam logic [CNT_W-1:0] OUT_SAT = 5'h1F;
  // ==========================================================
  // Command codes
  localparam logic [CMD_W-1:0] CMD_CHAN_LAST = 4'h7;
  localparam logic [CMD_W-1:0] CMD_PWR_DOWN = 4'h8;
  localparam logic [CMD_W-1:0] CMD_FAST = 4'h9;
  localparam logic [CMD_W-1:0] CMD_SLOW = 4'hA;
  localparam logic [CMD_W-1:0] CMD_TEST_FIRST = 4'hB;
  localparam logic [CMD_W-1:0] CMD_TEST_LAST = 4'hD;
  // ==========================================================
  // Reset values
  localparam logic [CMD_W-1:0] CMD_RST = 4'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  // ==========================================================
  // Port state, Gray coded along idle -> transfer -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_XFER = 2'h1
  } adcsp_state_t;
endpackage : adcsp_pkg

// ===== hdl/adcsp_port.sv
/*
  Serial host port of a 10-bit converter: command in, previous result out.
  Assumes the converter core sits outside and pulses conv_complete with
  conv_result in the clk domain; all pins are asynchronous to clk.
*/
`timescale 1ns/1ns
module adcsp_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic chip_select_n,
  input wire logic serial_shift_clock,
  input wire logic serial_in_line,
  input wire logic frame_sync,
  input wire logic clock_polarity_select,
  input wire logic conv_complete,
  input wire logic [adcsp_pkg::RES_W-1:0] conv_result,
  output logic serial_out_line,
  output logic serial_out_oe,
  output logic conversion_done,
  output logic host_type_flag,
  output logic [adcsp_pkg::CMD_W-1:0] command_word,
  output logic command_valid,
  output logic sampling,
  output logic conversion_start,
  output logic power_down,
  output logic rate_slow
);
  // ==========================================================
  // State record
  typedef struct packed {
    adcsp_pkg::adcsp_state_t st;
    logic host_type;
    logic sdo;
    logic sdo_oe;
    logic done;
    logic smp;
    logic conv_start;
    logic cmd_valid;
    logic pwr_down;
    logic slow;
    logic [2:0] in_cnt;
    logic [adcsp_pkg::CNT_W-1:0] cyc_cnt;
    logic [adcsp_pkg::CNT_W-1:0] out_cnt;
    logic [adcsp_pkg::CMD_W-1:0] cmd_sh;
    logic [adcsp_pkg::CMD_W-1:0] cmd;
    logic [adcsp_pkg::RES_W-1:0] shreg;
    logic [adcsp_pkg::RES_W-1:0] result;
  } adcsp_regs_t;

  adcsp_regs_t s_r;
  adcsp_regs_t s_nxt;

  // ==========================================================
  // Pin synchronisers and edge finders
  logic [adcsp_pkg::PIN_W-1:0] pins_s;
  logic [adcsp_pkg::PIN_W-1:0] pins_rise;
  logic [adcsp_pkg::PIN_W-1:0] pins_fall;
  logic pol_s;
  logic sdi_s;

  adcsp_sync #(
    .W(adcsp_pkg::PIN_W),
    .RST_VAL(adcsp_pkg::PIN_RST)
  ) u_sync_pins (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({frame_sync, serial_shift_clock, chip_select_n}),
    .q(pins_s)
  );

  adcsp_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_sync_data (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({clock_polarity_select, serial_in_line}),
    .q({pol_s, sdi_s})
  );

  adcsp_edge #(
    .W(adcsp_pkg::PIN_W),
    .RST_VAL(adcsp_pkg::PIN_RST)
  ) u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .lvl(pins_s),
    .rise(pins_rise),
    .fall(pins_fall)
  );

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic fs_s;
  logic in_edge;
  logic out_edge;
  logic cyc_edge;
  logic frame_open;

  // ==========================================================
  // Edge selection by host type and polarity
  function automatic logic edge_pick(input logic mode, input logic pol,
                                     input logic r, input logic f);
    edge_pick = mode ? (pol ? r : f) : (pol ? f : r);
  endfunction : edge_pick

  function automatic logic is_conv(input logic [adcsp_pkg::CMD_W-1:0] c);
    is_conv = (c <= adcsp_pkg::CMD_CHAN_LAST) ||
              (c >= adcsp_pkg::CMD_TEST_FIRST && c <= adcsp_pkg::CMD_TEST_LAST);
  endfunction : is_conv

  always_comb begin
    cs_fall = pins_fall[adcsp_pkg::PIN_CS];
    cs_rise = pins_rise[adcsp_pkg::PIN_CS];
    sclk_rise = pins_rise[adcsp_pkg::PIN_SCLK];
    sclk_fall = pins_fall[adcsp_pkg::PIN_SCLK];
    fs_s = pins_s[adcsp_pkg::PIN_FS];
    in_edge = edge_pick(s_r.host_type, pol_s, sclk_rise, sclk_fall);
    out_edge = edge_pick(s_r.host_type, 1'b0, sclk_rise, sclk_fall);
    cyc_edge = edge_pick(s_r.host_type, 1'b1, sclk_rise, sclk_fall);
    frame_open = s_r.host_type || !fs_s;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.cmd_valid = 1'b0;
    if (cs_rise) begin
      s_nxt.st = adcsp_pkg::ST_IDLE;
      s_nxt.sdo_oe = 1'b0;
      s_nxt.smp = 1'b0;
    end else if (cs_fall) begin
      s_nxt.st = adcsp_pkg::ST_XFER;
      s_nxt.host_type = fs_s;
      s_nxt.sdo_oe = 1'b1;
      s_nxt.in_cnt = '0;
      s_nxt.cyc_cnt = '0;
      s_nxt.out_cnt = '0;
      s_nxt.smp = 1'b0;
      s_nxt.pwr_down = 1'b0;
      s_nxt.sdo = fs_s & s_r.result[adcsp_pkg::RES_W-1];
      s_nxt.shreg = fs_s ? {s_r.result[adcsp_pkg::RES_W-2:0], 1'b0} : s_r.result;
    end else if (s_r.st != adcsp_pkg::ST_IDLE) begin
      if (!s_r.host_type && sclk_fall && fs_s) begin
        s_nxt.in_cnt = '0;
        s_nxt.cyc_cnt = '0;
        s_nxt.out_cnt = '0;
        s_nxt.smp = 1'b0;
        s_nxt.shreg = s_r.result;
      end else begin
        if (out_edge) begin
          s_nxt.sdo = s_r.shreg[adcsp_pkg::RES_W-1];
          s_nxt.shreg = {s_r.shreg[adcsp_pkg::RES_W-2:0], 1'b0};
          if (s_r.out_cnt != adcsp_pkg::OUT_SAT) begin
            s_nxt.out_cnt = s_r.out_cnt + 5'h01;
          end
        end
        if (in_edge && frame_open && s_r.in_cnt < adcsp_pkg::CMD_EDGES) begin
          s_nxt.cmd_sh = {s_r.cmd_sh[adcsp_pkg::CMD_W-2:0], sdi_s};
          s_nxt.in_cnt = s_r.in_cnt + 3'h1;
          if (s_r.in_cnt == adcsp_pkg::CMD_EDGES - 3'h1) begin
            s_nxt.cmd = {s_r.cmd_sh[adcsp_pkg::CMD_W-2:0], sdi_s};
            s_nxt.cmd_valid = 1'b1;
          end
        end
        if (cyc_edge && frame_open && s_r.cyc_cnt < adcsp_pkg::FRAME_EDGES) begin
          s_nxt.cyc_cnt = s_r.cyc_cnt + 5'h01;
          if (s_r.cyc_cnt + 5'h01 == adcsp_pkg::SAMPLE_EDGE) begin
            s_nxt.smp = 1'b1;
          end
          if (s_r.cyc_cnt + 5'h01 == adcsp_pkg::CONV_EDGE) begin
            s_nxt.smp = 1'b0;
            if (is_conv(s_r.cmd)) begin
              s_nxt.done = 1'b0;
              s_nxt.conv_start = 1'b1;
            end else if (s_r.cmd == adcsp_pkg::CMD_PWR_DOWN) begin
              s_nxt.pwr_down = 1'b1;
            end else if (s_r.cmd == adcsp_pkg::CMD_FAST) begin
              s_nxt.slow = 1'b0;
            end else if (s_r.cmd == adcsp_pkg::CMD_SLOW) begin
              s_nxt.slow = 1'b1;
            end
          end
        end
      end
    end
    if (conv_complete && !s_r.done) begin
      s_nxt.done = 1'b1;
      s_nxt.result = conv_result;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.st <= adcsp_pkg::ST_IDLE;
      s_r.host_type <= 1'b1;
      s_r.sdo <= 1'b0;
      s_r.sdo_oe <= 1'b0;
      s_r.done <= 1'b1;
      s_r.smp <= 1'b0;
      s_r.conv_start <= 1'b0;
      s_r.cmd_valid <= 1'b0;
      s_r.pwr_down <= 1'b0;
      s_r.slow <= 1'b0;
      s_r.in_cnt <= '0;
      s_r.cyc_cnt <= '0;
      s_r.out_cnt <= '0;
      s_r.cmd_sh <= adcsp_pkg::CMD_RST;
      s_r.cmd <= adcsp_pkg::CMD_RST;
      s_r.shreg <= adcsp_pkg::RESULT_RST;
      s_r.result <= adcsp_pkg::RESULT_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign serial_out_line = s_r.sdo;
  assign serial_out_oe = s_r.sdo_oe;
  assign conversion_done = s_r.done;
  assign host_type_flag = s_r.host_type;
  assign command_word = s_r.cmd;
  assign command_valid = s_r.cmd_valid;
  assign sampling = s_r.smp;
  assign conversion_start = s_r.conv_start;
  assign power_down = s_r.pwr_down;
  assign rate_slow = s_r.slow;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sel_fall;
    ce && cs_fall;
  endsequence

  sequence s_sel_rise;
    ce && cs_rise;
  endsequence

  sequence s_dsp_restart;
    ce && s_r.st != adcsp_pkg::ST_IDLE && !s_r.host_type && sclk_fall && fs_s
      && !cs_rise && !cs_fall;
  endsequence

  a_idle_float: assert property (
    s_r.st == adcsp_pkg::ST_IDLE |-> !s_r.sdo_oe)
    else $error("data out driven while deselected");

  a_select_drives: assert property (
    s_sel_fall |=> s_r.sdo_oe && s_r.st == adcsp_pkg::ST_XFER)
    else $error("select fall did not start transfer");

  a_mode_latch: assert property (
    s_sel_fall |=> s_r.host_type == $past(fs_s))
    else $error("host type not latched from frame sync");

  a_msb_first: assert property (
    (s_sel_fall and (ce && fs_s)) |=> s_r.sdo == $past(s_r.result[adcsp_pkg::RES_W-1]))
    else $error("MSB not presented at select fall");

  a_cmd_four: assert property (
    s_r.cmd_valid |-> s_r.in_cnt == adcsp_pkg::CMD_EDGES && s_r.cmd == s_r.cmd_sh)
    else $error("command taken at wrong bit count");

  a_conv_tenth: assert property (
    $fell(s_r.done) |-> s_r.cyc_cnt == adcsp_pkg::CONV_EDGE && s_r.conv_start)
    else $error("conversion started at wrong edge");

  a_done_load: assert property (
    ce && conv_complete && !s_r.done |=> s_r.done && s_r.result == $past(conv_result))
    else $error("completion did not load result");

  a_tail_zero: assert property (
    s_r.st == adcsp_pkg::ST_XFER && s_r.out_cnt >= (s_r.host_type ? 5'h0A : 5'h0B)
      |-> !s_r.sdo)
    else $error("data out not zero after ten bits");

  a_release: assert property (
    s_sel_rise |=> !s_r.sdo_oe ##1 !s_r.sdo_oe)
    else $error("select rise did not float data out");

  a_abort_keep: assert property (
    s_sel_fall and (ce && !conv_complete) |=> s_r.result == $past(s_r.result))
    else $error("abort changed stored result");

  a_dsp_reset: assert property (
    s_dsp_restart |=> s_r.in_cnt == 3'h0 && s_r.cyc_cnt == 5'h00)
    else $error("frame sync did not reset counters");

  a_dsp_reload: assert property (
    s_dsp_restart |=> s_r.shreg == $past(s_r.result) && s_r.out_cnt == 5'h00)
    else $error("frame sync did not reload output register");

  a_dsp_msb: assert property (
    s_r.st == adcsp_pkg::ST_XFER && !s_r.host_type && s_r.out_cnt == 5'h01
      && $changed(s_r.out_cnt) |-> s_r.sdo == s_r.result[adcsp_pkg::RES_W-1])
    else $error("DSP frame did not open with MSB");

  a_sample_start: assert property (
    $rose(s_r.smp) |-> s_r.cyc_cnt == adcsp_pkg::SAMPLE_EDGE)
    else $error("sampling started at wrong edge");

  a_idle_cmd_hold: assert property (
    s_r.st == adcsp_pkg::ST_IDLE |=> $stable(s_r.cmd))
    else $error("command changed while deselected");

  a_pwr_clear: assert property (
    s_sel_fall |=> !s_r.pwr_down)
    else $error("select fall did not clear power down");
endmodule : adcsp_port

// ===== hdl/adcsp_sync.sv
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes inputs are asynchronous to clk; reset value is a parameter.
*/
`timescale 1ns/1ns
module adcsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } adcsp_sync_t;

  adcsp_sync_t s_r;
  adcsp_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= {RST_VAL, RST_VAL};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.sync;
endmodule : adcsp_sync

// ===== tb/adcsp_host_model.sv
/*
  Host serial port model: drives select, shift clock, frame sync, polarity
  and data in of the converter port, and collects its data out.
  Assumes clk at 25 MHz; one shift-clock half period is four clk cycles.
*/
`timescale 1ns/1ns
module adcsp_host_model (
  input wire logic clk,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  output logic chip_select_n,
  output logic serial_shift_clock,
  output logic serial_in_line,
  output logic frame_sync,
  output logic clock_polarity_select
);
  initial begin
    chip_select_n = 1'b1;
    serial_shift_clock = 1'b0;
    serial_in_line = 1'b0;
    frame_sync = 1'b1;
    clock_polarity_select = 1'b1;
  end
  // ==========================================================
  // Half period; data and frame sync move mid phase
  task automatic sck(input logic v, input logic d, input logic f);
    serial_shift_clock <= v;
    repeat (2) @(posedge clk);
    serial_in_line <= d;
    frame_sync <= f;
    repeat (2) @(posedge clk);
  endtask : sck
  // ==========================================================
  // Shift clocks while select is high
  task automatic idle(input int k);
    repeat (k) begin
      sck(1'b1, ~serial_in_line, frame_sync);
      sck(1'b0, ~serial_in_line, frame_sync);
    end
  endtask : idle
  // ==========================================================
  // One transfer of n counting cycles
  task automatic xfer(input logic dsp, input logic pol, input logic [3:0] cmd, input int n,
                      output logic [15:0] rx, output logic oe_ok);
    int i;
    rx = 16'h0000;
    oe_ok = 1'b1;
    clock_polarity_select <= pol;
    sck(1'b0, ~serial_in_line, ~dsp);
    chip_select_n <= 1'b0;
    sck(1'b0, cmd[3], ~dsp);
    if (dsp) begin
      sck(1'b0, cmd[3], 1'b1);
      sck(1'b1, cmd[3], 1'b1);
      sck(1'b0, cmd[3], 1'b1);
      sck(1'b1, cmd[3], 1'b0);
    end
    for (i = 0; i < n; i++) begin
      rx[15 - i] = serial_out_oe ? serial_out_line : ~serial_out_line;
      oe_ok &= serial_out_oe;
      sck(~dsp, serial_in_line, ~dsp);
      sck(dsp, (i < 3) ? cmd[2 - i] : ~serial_in_line, ~dsp);
    end
    chip_select_n <= 1'b1;
    sck(serial_shift_clock, ~serial_in_line, frame_sync);
    sck(1'b0, ~serial_in_line, frame_sync);
  endtask : xfer
endmodule : adcsp_host_model

// ===== tb/tb_adcsp_port.sv
/*
  Self-checking bench for the converter serial host port.
  Assumes the host model drives the pins; the bench plays the converter core.
*/
`timescale 1ns/1ns
module tb_adcsp_port;
  typedef struct packed {
    logic d;
    logic p;
    logic [4:0] n;
    logic [3:0] c;
    logic [9:0] r;
    logic s;
    logic pd;
    logic sl;
  } adcsp_row_t;
  logic clk, rst_n, ce, conv_complete, oe_ok;
  logic [9:0] conv_result, prev;
  logic [15:0] rx;
  wire cs_n, sclk, sdin, fs, pol, sdout, oe, done, htf, cv, samp, cst, pd, slow;
  wire [3:0] cmd_w;
  int num_errors, compares, n_cv, n_st, seen_samp;
  adcsp_row_t rows[16] = '{
    '{1'b0, 1'b1, 5'h0A, 4'h0, 10'h2A5, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b1, 5'h10, 4'h1, 10'h1C3, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 5'h10, 4'h2, 10'h3FF, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b0, 5'h0A, 4'h3, 10'h000, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b1, 5'h0C, 4'h4, 10'h155, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b1, 5'h10, 4'h5, 10'h2AA, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 5'h0B, 4'h6, 10'h001, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b0, 5'h10, 4'h7, 10'h200, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b1, 5'h0A, 4'h8, 10'h000, 1'b0, 1'b1, 1'b0},
    '{1'b0, 1'b0, 5'h0A, 4'hA, 10'h000, 1'b0, 1'b0, 1'b1},
    '{1'b1, 1'b1, 5'h10, 4'hB, 10'h200, 1'b1, 1'b0, 1'b1},
    '{1'b0, 1'b1, 5'h0A, 4'hC, 10'h000, 1'b1, 1'b0, 1'b1},
    '{1'b1, 1'b0, 5'h10, 4'h9, 10'h000, 1'b0, 1'b0, 1'b0},
    '{1'b0, 1'b1, 5'h0A, 4'hD, 10'h3FF, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 5'h0A, 4'hE, 10'h000, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b1, 5'h10, 4'hF, 10'h000, 1'b0, 1'b0, 1'b0}};
  adcsp_host_model hm (.clk(clk), .serial_out_line(sdout), .serial_out_oe(oe),
    .chip_select_n(cs_n), .serial_shift_clock(sclk), .serial_in_line(sdin),
    .frame_sync(fs), .clock_polarity_select(pol));
  adcsp_port DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .chip_select_n(cs_n),
    .serial_shift_clock(sclk), .serial_in_line(sdin), .frame_sync(fs),
    .clock_polarity_select(pol), .conv_complete(conv_complete), .conv_result(conv_result),
    .serial_out_line(sdout), .serial_out_oe(oe), .conversion_done(done),
    .host_type_flag(htf), .command_word(cmd_w), .command_valid(cv), .sampling(samp),
    .conversion_start(cst), .power_down(pd), .rate_slow(slow));
  // ==========================================================
  // Clock and pulse counters
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cv === 1'b1) n_cv++;
    if (cst === 1'b1) n_st++;
    if (samp === 1'b1) seen_samp = 1;
  end
  // ==========================================================
  // Checking tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic clr();
    @(negedge clk);
    n_cv = 0;
    n_st = 0;
    seen_samp = 0;
    @(posedge clk);
  endtask : clr
  task automatic rst_chk();
    chk("rst_oe", 0, oe);
    chk("rst_done", 1, done);
    chk("rst_host_type", 1, htf);
    chk("rst_command", 0, cmd_w);
    chk("rst_modes", 0, {pd, slow});
  endtask : rst_chk
  task automatic run(input adcsp_row_t w);
    logic [15:0] m;
    clr();
    hm.xfer(w.d, w.p, w.c, int'(w.n), rx, oe_ok);
    m = 16'hFFFF << (16 - w.n);
    chk("data_out", {prev, 6'h00} & m, rx & m);
    chk("oe_in_frame", 1, oe_ok);
    chk("oe_idle", 0, oe);
    chk("host_type", !w.d, htf);
    chk("command", w.c, cmd_w);
    chk("cmd_valid", w.n >= 4, 16'(n_cv));
    chk("conv_start", w.s, 16'(n_st));
    chk("sampling", w.n >= 4, 16'(seen_samp));
    chk("done_low", !w.s, done);
    chk("power_down", w.pd, pd);
    chk("rate_slow", w.sl, slow);
    if (w.s) begin
      conv_complete <= 1'b1;
      conv_result <= w.r;
      @(posedge clk);
      conv_complete <= 1'b0;
      repeat (2) @(posedge clk);
      chk("done_high", 1, done);
      prev = w.r;
    end
  endtask : run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    conv_complete = 1'b0;
    conv_result = 10'h000;
    prev = 10'h000;
    num_errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rst_chk();
    $display("Test reset done");
    foreach (rows[r]) begin
      run(rows[r]);
      $display("Test row %0d done", r);
    end
    clr();
    hm.idle(6);
    chk("idle_cmd_valid", 0, 16'(n_cv));
    chk("idle_oe", 0, oe);
    chk("idle_command", 4'hF, cmd_w);
    $display("Test idle clocks done");
    run('{1'b0, 1'b1, 5'h06, 4'h3, 10'h111, 1'b0, 1'b0, 1'b0});
    run('{1'b0, 1'b0, 5'h09, 4'h5, 10'h111, 1'b0, 1'b0, 1'b0});
    run('{1'b1, 1'b1, 5'h10, 4'h1, 10'h0F0, 1'b1, 1'b0, 1'b0});
    $display("Test short transfers done");
    ce <= 1'b0;
    clr();
    hm.xfer(1'b0, 1'b1, 4'h5, 10, rx, oe_ok);
    chk("frozen_oe", 0, oe_ok);
    chk("frozen_cmd", 4'h1, cmd_w);
    chk("frozen_pulses", 0, 16'(n_cv + n_st));
    chk("frozen_done", 1, done);
    ce <= 1'b1;
    $display("Test clock enable done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_chk();
    rst_n <= 1'b1;
    prev = 10'h000;
    run('{1'b0, 1'b1, 5'h0A, 4'h2, 10'h0AA, 1'b1, 1'b0, 1'b0});
    $display("Test second reset done");
    end_of_test();
  end
  // ==========================================================
  // Watchdog: the run needs about 2700 cycles
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : tb_adcsp_port
